// >>> adc_seq_map.svh
// Field positions, reset values and timing counts of the conversion sequencer
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH

// First status/control register fields
`define SC1_IRQ_EN_BIT 6
`define SC1_CONT_BIT 5
`define SC1_CHAN_HI 4
`define SC1_CHAN_LO 0
`define SC1_RESET 8'h1f
`define CHAN_OFF 5'h1f

// Second status/control register fields
`define SC2_ACTIVE_BIT 7
`define SC2_TRIG_BIT 6
`define SC2_CMP_EN_BIT 5
`define SC2_CMP_GT_BIT 4
`define SC2_RESET 8'h00

// Configuration register fields
`define CFG_LOW_POWER_BIT 7
`define CFG_DIV_HI 6
`define CFG_DIV_LO 5
`define CFG_LONG_BIT 4
`define CFG_MODE_HI 3
`define CFG_MODE_LO 2
`define CFG_SRC_HI 1
`define CFG_SRC_LO 0
`define CFG_RESET 8'h00
`define MODE_TEN 2'h2
`define SRC_BUS 2'h0
`define SRC_BUS_HALF 2'h1
`define SRC_ALT 2'h2
`define SRC_ASYNC 2'h3

// Result and compare reset values
`define RESULT_RESET 8'h00
`define CMP_RESET 8'h00

// Conversion phases in converter clock cycles; the bus overhead in bus clock cycles
`define SAMPLE_SHORT_CYC 3
`define SAMPLE_LONG_CYC 23
`define SAR_EIGHT_CYC 14
`define SAR_TEN_CYC 17
`define FIRST_EXTRA_CYC 3
`define BUS_OVERHEAD_CYC 5

// Startup allowance of the internal asynchronous clock
`define CLK_PERIOD_NS 20
`define STARTUP_NS 5000
`define STARTUP_CYC ((`STARTUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> adc_seq_pkg.sv
// Types shared by the conversion sequencer files
package adc_seq_pkg;

  // Sequencer phases
  typedef enum logic [2:0] {
    S_IDLE,
    S_STARTUP,
    S_OVERHEAD,
    S_EXTRA,
    S_SAMPLE,
    S_CONVERT
  } conv_state_t;

  typedef logic [1:0] clk_src_t;

endpackage

// >>> conv_clock_gen.sv
// Converter clock tick generator: source select and power-of-two divider
`include "adc_seq_map.svh"

module conv_clock_gen (
  input wire logic clk_sys_i, // Bus clock
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic run_i, // Converter active; divider cleared when low
  input wire adc_seq_pkg::clk_src_t src_i, // Clock source select
  input wire logic [1:0] div_i, // Divide select: 1, 2, 4 or 8
  input wire logic alt_tick_i, // Alternate clock tick, one cycle
  input wire logic async_tick_i, // Internal asynchronous clock tick
  output logic tick_o // One converter clock cycle elapsed
);

  logic half_q;
  logic [2:0] div_cnt_q;
  logic [2:0] div_cnt_d;
  logic tick_q;
  logic tick_d;
  logic src_tick_w;
  logic [2:0] div_mask_w;

  // Source selection; half rate toggles only while running
  assign src_tick_w = (src_i == `SRC_BUS) ? 1'b1 :
                      (src_i == `SRC_BUS_HALF) ? half_q :
                      (src_i == `SRC_ALT) ? alt_tick_i : async_tick_i;
  assign div_mask_w = 3'(({1'b0, 3'h1} << div_i) - 4'h1);
  assign tick_d = run_i && src_tick_w && ((div_cnt_q & div_mask_w) == div_mask_w);
  assign div_cnt_d = !run_i ? 3'h0 : (src_tick_w ? 3'(div_cnt_q + 3'h1) : div_cnt_q);

  // Divider restarts when a run starts from idle so the first phase is full length
  always_ff @(posedge clk_sys_i) begin
    if (srst_i || !run_i) begin
      half_q <= 1'b0;
    end else begin
      half_q <= ~half_q;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      div_cnt_q <= 3'h0;
      tick_q <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q;

endmodule // conv_clock_gen

// >>> adc_conversion_sequencer.sv
// Conversion sequencer of a successive-approximation converter
//
// Behaviour
// - Software trigger: each first-register write starts a conversion unless channel is all ones.
// - Hardware trigger selected: trigger event starts conversion, register writes do not.
// - Continuous mode relaunches after each transfer until an abort.
// - Completion transfers result, sets flag; interrupt only if enabled when flag sets.
// - 10-bit, high byte read but low not: result dropped, flag not set, data kept.
// - Blocked single with compare false halts; other blocked transfers start another conversion.
// - First-register write aborts conversion, then restarts under software trigger unless channel is all ones.
// - Writes to second register, configuration or compare values abort conversion.
// - Reset aborts; stop mode aborts unless asynchronous clock is selected.
// - Abort keeps last results; reset returns them to reset values.
// - Idle until started; asynchronous clock enabled only when selected and active.
// - Sample short or long, then isolate input, approximate, transfer.
// - Sync clock, short sample: first takes 20 or 23 converter plus 5 bus cycles.
// - Sync clock, long sample: first takes 40 or 43 converter plus 5 bus cycles.
// - Asynchronous clock adds a startup delay to first conversions.
// - Subsequent continuous: 17/20 short, 37/40 long converter cycles, no bus overhead.
// - Compare adds two's complement of limit; greater-or-equal or less by direction bit.
// - Compare true stores the sum and sets flag; false transfers nothing.
// - Wait mode: conversions complete, may start by trigger or continuous, interrupt wakes.
// - Wait mode keeps bus, half bus and asynchronous clocks usable.
// - Converter disabled during reset and when channel is written all ones.
// - 10-bit fills both result registers; 8-bit result goes to low register only.
// - Hardware trigger starts on rising edge; edges during a conversion are ignored.
`include "adc_seq_map.svh"

module adc_conversion_sequencer (
  input wire logic clk_sys_i, // Bus clock, 50 MHz
  input wire logic srst_i, // Synchronous reset, active high
  input wire logic sc1_wr_i, // Write strobe, first status/control register
  input wire logic [7:0] sc1_wdata_i, // Write data, first status/control register
  input wire logic sc2_wr_i, // Write strobe, second status/control register
  input wire logic [7:0] sc2_wdata_i, // Write data, second status/control register
  input wire logic cfg_wr_i, // Write strobe, configuration register
  input wire logic [7:0] cfg_wdata_i, // Write data, configuration register
  input wire logic cvh_wr_i, // Write strobe, compare value high
  input wire logic cvl_wr_i, // Write strobe, compare value low
  input wire logic [7:0] cv_wdata_i, // Write data, either compare value
  input wire logic rh_rd_i, // Read strobe, high result byte
  input wire logic rl_rd_i, // Read strobe, low result byte
  input wire logic hw_trigger_in_i, // Hardware trigger level
  input wire logic stop_mode_i, // Processor in stop mode
  input wire logic wait_mode_i, // Processor in wait mode
  input wire logic alt_tick_i, // Alternate clock tick
  input wire logic async_tick_i, // Internal asynchronous clock tick
  input wire logic [9:0] sar_data_i, // Rounded approximation result
  output logic [7:0] status_control_one_o, // First status/control readback
  output logic [7:0] status_control_two_o, // Second status/control readback
  output logic [7:0] converter_config_o, // Configuration readback
  output logic [7:0] compare_value_high_o, // Compare value high readback
  output logic [7:0] compare_value_low_o, // Compare value low readback
  output logic [7:0] result_high_o, // High result byte
  output logic [7:0] result_low_o, // Low result byte
  output logic complete_flag_o, // Conversion complete flag
  output logic irq_o, // Completion interrupt, level
  output logic [4:0] channel_select_o, // Channel to the analog mux
  output logic sample_o, // Input connected for sampling
  output logic convert_o, // Input isolated, approximation running
  output logic low_power_config_o, // Low power setting to analog core
  output logic async_clk_en_o, // Enable of the asynchronous clock generator
  output logic wake_o // Wake request while in wait mode
);

  adc_seq_pkg::conv_state_t state_q;
  adc_seq_pkg::conv_state_t state_d;
  adc_seq_pkg::conv_state_t first_state_w;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] first_cnt_w;
  logic [7:0] sample_cnt_w;
  logic [7:0] sar_cnt_w;
  logic [7:0] sc1_q;
  logic [7:0] sc2_q;
  logic [7:0] cfg_q;
  logic [1:0] cvh_q;
  logic [7:0] cvl_q;
  logic [7:0] res_hi_q;
  logic [7:0] res_lo_q;
  logic complete_flag_q;
  logic irq_q;
  logic hi_pending_q;
  logic trig_prev_q;
  logic tick_w;
  logic active_w;
  logic trig_sel_w;
  logic cmp_en_w;
  logic cmp_gt_w;
  logic cont_w;
  logic mode_ten_w;
  logic async_src_w;
  logic hw_edge_w;
  logic stop_abort_w;
  logic abort_w;
  logic sw_start_w;
  logic hw_start_w;
  logic done_w;
  logic blocked_w;
  logic ge_w;
  logic cond_w;
  logic pass_w;
  logic xfer_w;
  logic halt_w;
  logic complete_flag_clr_w;
  logic [9:0] cv_full_w;
  logic [10:0] diff_ten_w;
  logic [8:0] diff_eight_w;
  logic [9:0] store_w;

  // Field decode of the control registers
  assign trig_sel_w = sc2_q[`SC2_TRIG_BIT];
  assign cmp_en_w = sc2_q[`SC2_CMP_EN_BIT];
  assign cmp_gt_w = sc2_q[`SC2_CMP_GT_BIT];
  assign cont_w = sc1_q[`SC1_CONT_BIT];
  assign mode_ten_w = (cfg_q[`CFG_MODE_HI:`CFG_MODE_LO] == `MODE_TEN);
  assign async_src_w = (cfg_q[`CFG_SRC_HI:`CFG_SRC_LO] == `SRC_ASYNC);
  assign active_w = (state_q != adc_seq_pkg::S_IDLE);

  // Trigger and abort decode; the trigger input is synchronous to the bus clock
  assign hw_edge_w = hw_trigger_in_i && !trig_prev_q;
  assign stop_abort_w = stop_mode_i && !async_src_w;
  assign abort_w = sc1_wr_i || sc2_wr_i || cfg_wr_i || cvh_wr_i || cvl_wr_i
                   || stop_abort_w;
  assign sw_start_w = sc1_wr_i && !trig_sel_w
                      && (sc1_wdata_i[`SC1_CHAN_HI:`SC1_CHAN_LO] != `CHAN_OFF);
  // Edges seen while busy are dropped; only the launching edge of a run counts
  assign hw_start_w = trig_sel_w && hw_edge_w && !active_w && !abort_w
                      && (sc1_q[`SC1_CHAN_HI:`SC1_CHAN_LO] != `CHAN_OFF);

  // Phase lengths in converter clock cycles
  assign sample_cnt_w = cfg_q[`CFG_LONG_BIT] ? 8'(`SAMPLE_LONG_CYC - 1)
                                             : 8'(`SAMPLE_SHORT_CYC - 1);
  assign sar_cnt_w = mode_ten_w ? 8'(`SAR_TEN_CYC - 1) : 8'(`SAR_EIGHT_CYC - 1);
  // First conversions pay the bus overhead first, after the startup allowance when the asynchronous clock is selected
  assign first_state_w = async_src_w ? adc_seq_pkg::S_STARTUP
                                     : adc_seq_pkg::S_OVERHEAD;
  assign first_cnt_w = async_src_w ? 8'(`STARTUP_CYC - 1) : 8'(`BUS_OVERHEAD_CYC - 1);

  // Compare: result plus two's complement of the limit; carry out means greater or equal
  assign cv_full_w = {cvh_q, cvl_q};
  assign diff_ten_w = 11'({1'b0, sar_data_i} + {1'b0, ~cv_full_w} + 11'h001);
  assign diff_eight_w = 9'({1'b0, sar_data_i[7:0]} + {1'b0, ~cvl_q} + 9'h001);
  assign ge_w = mode_ten_w ? diff_ten_w[10] : diff_eight_w[8];
  assign cond_w = cmp_gt_w ? ge_w : !ge_w;
  assign store_w = !cmp_en_w ? sar_data_i
                 : (mode_ten_w ? diff_ten_w[9:0] : {2'h0, diff_eight_w[7:0]});

  // Completion decode; an abort in the last cycle wins over the transfer
  assign done_w = (state_q == adc_seq_pkg::S_CONVERT) && tick_w && (cnt_q == 8'h00)
                  && !abort_w;
  assign blocked_w = mode_ten_w && hi_pending_q;
  assign pass_w = !cmp_en_w || cond_w;
  assign xfer_w = done_w && !blocked_w && pass_w;
  assign halt_w = blocked_w && !cont_w && cmp_en_w && !cond_w;
  assign complete_flag_clr_w = sc1_wr_i || rl_rd_i;

  // Sequencer next state; wait mode does not gate anything, so runs finish there
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (abort_w) begin
      state_d = adc_seq_pkg::S_IDLE;
      if (sw_start_w) begin
        state_d = first_state_w;
        cnt_d = first_cnt_w;
      end
    end else if (hw_start_w) begin
      state_d = first_state_w;
      cnt_d = first_cnt_w;
    end else begin
      unique case (state_q)
        adc_seq_pkg::S_IDLE: begin
          cnt_d = 8'h00;
        end
        adc_seq_pkg::S_STARTUP: begin
          if (cnt_q == 8'h00) begin
            state_d = adc_seq_pkg::S_OVERHEAD;
            cnt_d = 8'(`BUS_OVERHEAD_CYC - 1);
          end else begin
            cnt_d = 8'(cnt_q - 8'h01);
          end
        end
        adc_seq_pkg::S_OVERHEAD: begin
          if (cnt_q == 8'h00) begin
            state_d = adc_seq_pkg::S_EXTRA;
            cnt_d = 8'(`FIRST_EXTRA_CYC - 1);
          end else begin
            cnt_d = 8'(cnt_q - 8'h01);
          end
        end
        adc_seq_pkg::S_EXTRA: begin
          if (tick_w && cnt_q == 8'h00) begin
            state_d = adc_seq_pkg::S_SAMPLE;
            cnt_d = sample_cnt_w;
          end else if (tick_w) begin
            cnt_d = 8'(cnt_q - 8'h01);
          end
        end
        adc_seq_pkg::S_SAMPLE: begin
          if (tick_w && cnt_q == 8'h00) begin
            state_d = adc_seq_pkg::S_CONVERT;
            cnt_d = sar_cnt_w;
          end else if (tick_w) begin
            cnt_d = 8'(cnt_q - 8'h01);
          end
        end
        adc_seq_pkg::S_CONVERT: begin
          if (done_w && cont_w) begin
            state_d = adc_seq_pkg::S_SAMPLE;
            cnt_d = sample_cnt_w;
          end else if (done_w && blocked_w && !halt_w) begin
            state_d = first_state_w;
            cnt_d = first_cnt_w;
          end else if (done_w) begin
            state_d = adc_seq_pkg::S_IDLE;
          end else if (tick_w) begin
            cnt_d = 8'(cnt_q - 8'h01);
          end
        end
        default: begin
          state_d = adc_seq_pkg::S_IDLE;
        end
      endcase
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_q <= adc_seq_pkg::S_IDLE;
      cnt_q <= 8'h00;
      trig_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      trig_prev_q <= hw_trigger_in_i;
    end
  end

  // Control registers; channel resets to all ones so the converter starts disabled
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      sc1_q <= `SC1_RESET;
      sc2_q <= `SC2_RESET;
      cfg_q <= `CFG_RESET;
      cvh_q <= 2'h0;
      cvl_q <= `CMP_RESET;
    end else begin
      if (sc1_wr_i) sc1_q <= {1'b0, sc1_wdata_i[6:0]};
      if (sc2_wr_i) sc2_q <= {1'b0, sc2_wdata_i[6:4], 4'h0};
      if (cfg_wr_i) cfg_q <= cfg_wdata_i;
      if (cvh_wr_i) cvh_q <= cv_wdata_i[1:0];
      if (cvl_wr_i) cvl_q <= cv_wdata_i;
    end
  end

  // Result registers move only on a real transfer; aborts leave them alone
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      res_hi_q <= `RESULT_RESET;
      res_lo_q <= `RESULT_RESET;
    end else if (xfer_w) begin
      if (mode_ten_w) res_hi_q <= {6'h00, store_w[9:8]};
      res_lo_q <= store_w[7:0];
    end
  end

  // Flag, interrupt and read guard; a hardware set beats a same-cycle clear
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      complete_flag_q <= 1'b0;
      irq_q <= 1'b0;
      hi_pending_q <= 1'b0;
    end else begin
      complete_flag_q <= xfer_w || (complete_flag_q && !complete_flag_clr_w);
      irq_q <= (xfer_w && sc1_q[`SC1_IRQ_EN_BIT]) || (irq_q && !complete_flag_clr_w);
      hi_pending_q <= rh_rd_i || (hi_pending_q && !rl_rd_i);
    end
  end

  // Converter clock; sources stay selectable in wait mode
  conv_clock_gen u_clk (
    .clk_sys_i(clk_sys_i),
    .srst_i(srst_i),
    .run_i(active_w),
    .src_i(cfg_q[`CFG_SRC_HI:`CFG_SRC_LO]),
    .div_i(cfg_q[`CFG_DIV_HI:`CFG_DIV_LO]),
    .alt_tick_i(alt_tick_i),
    .async_tick_i(async_tick_i),
    .tick_o(tick_w)
  );

  // Outputs
  assign status_control_one_o = {complete_flag_q, sc1_q[6:0]};
  assign status_control_two_o = {active_w, sc2_q[6:0]};
  assign converter_config_o = cfg_q;
  assign compare_value_high_o = {6'h00, cvh_q};
  assign compare_value_low_o = cvl_q;
  assign result_high_o = res_hi_q;
  assign result_low_o = res_lo_q;
  assign complete_flag_o = complete_flag_q;
  assign irq_o = irq_q;
  assign wake_o = irq_q && wait_mode_i;
  assign channel_select_o = sc1_q[`SC1_CHAN_HI:`SC1_CHAN_LO];
  assign sample_o = (state_q == adc_seq_pkg::S_SAMPLE);
  assign convert_o = (state_q == adc_seq_pkg::S_CONVERT);
  assign low_power_config_o = cfg_q[`CFG_LOW_POWER_BIT];
  assign async_clk_en_o = active_w && async_src_w;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence s_first_sync;
    sw_start_w && !async_src_w;
  endsequence

  sequence s_quiet5;
    (!abort_w && !hw_start_w)[*5];
  endsequence

  property p_sw_start;
    sw_start_w |=> active_w;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("software write did not start");

  property p_chan_off;
    (sc1_wr_i && sc1_wdata_i[4:0] == `CHAN_OFF) |=> !active_w ##1 !sample_o;
  endproperty
  a_chan_off: assert property (p_chan_off) else $error("all-ones channel left converter on");

  property p_hw_start;
    (trig_sel_w && hw_edge_w && !active_w && !abort_w && channel_select_o != `CHAN_OFF)
      |=> active_w;
  endproperty
  a_hw_start: assert property (p_hw_start) else $error("trigger edge did not start");

  property p_hw_ignored;
    (active_w && !abort_w && !done_w) |=> state_q != first_state_w || $past(state_q) != adc_seq_pkg::S_CONVERT || $past(cnt_q) == 8'h00;
  endproperty
  a_hw_ignored: assert property (p_hw_ignored) else $error("conversion restarted mid-way");

  property p_mode_abort;
    (sc2_wr_i || cfg_wr_i || cvh_wr_i || cvl_wr_i) |=> !active_w;
  endproperty
  a_mode_abort: assert property (p_mode_abort) else $error("mode write did not abort");

  property p_stop_abort;
    (stop_mode_i && !async_src_w && !sc1_wr_i) |=> !active_w;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");

  property p_keep;
    (abort_w || (done_w && !xfer_w)) |=> $stable(res_hi_q) && $stable(res_lo_q);
  endproperty
  a_keep: assert property (p_keep) else $error("results changed without transfer");

  property p_blocked;
    (done_w && blocked_w) |=> !$rose(complete_flag_q) && $stable(res_lo_q);
  endproperty
  a_blocked: assert property (p_blocked) else $error("blocked result was transferred");

  property p_block_retry;
    (done_w && blocked_w && !halt_w && !cont_w) |=> state_q == first_state_w;
  endproperty
  a_block_retry: assert property (p_block_retry) else $error("blocked run not retried");

  property p_cont;
    (done_w && cont_w) |=> sample_o && cnt_q == sample_cnt_w;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous relaunch missing");

  property p_overhead;
    s_first_sync ##1 s_quiet5 |=> state_q == adc_seq_pkg::S_EXTRA;
  endproperty
  a_overhead: assert property (p_overhead) else $error("bus overhead not five cycles");

  property p_irq;
    $rose(complete_flag_q) |-> irq_o == $past(sc1_q[6]);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not tied to enable");

  property p_compare;
    (done_w && cmp_en_w && !cond_w) |=> !$rose(complete_flag_q);
  endproperty
  a_compare: assert property (p_compare) else $error("false compare set the flag");

endmodule // adc_conversion_sequencer

// >>> tb_adc_conversion_sequencer.sv
// Self-checking bench of the conversion sequencer
`include "adc_seq_map.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, a, e); end end

module tb_adc_conversion_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic srst_i = 1'b1;
  logic [5:0] wstb = 6'h00; // Strobes: sc1, sc2, cfg, cvh, cvl, stop
  logic [7:0] wd = 8'h00;
  logic rh_rd_i = 1'b0;
  logic rl_rd_i = 1'b0;
  logic hw_trigger_in_i = 1'b0;
  logic wait_mode_i = 1'b0;
  logic tick_q = 1'b0;
  logic [9:0] sar_data_i = 10'h000;
  logic [7:0] sc1, sc2, rh, rl, cfg, cvh, cvl;
  logic flag, irq, smp, cnv, aen, wake, lp;
  logic [4:0] chan;
  int n_mismatch = 0;
  int checked = 0;
  int n;

  // Bus clock and a half-rate tick for the alternate and asynchronous sources
  always #10 clk_sys_i = ~clk_sys_i;
  // Ticks never outpace the bus clock, so continuous timing stays exact
  always @(posedge clk_sys_i) tick_q <= ~tick_q;

  adc_conversion_sequencer adc_conversion_sequencer_inst (
    .clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .sc1_wr_i(wstb[0]), .sc1_wdata_i(wd), .sc2_wr_i(wstb[1]), .sc2_wdata_i(wd),
    .cfg_wr_i(wstb[2]), .cfg_wdata_i(wd), .cvh_wr_i(wstb[3]), .cvl_wr_i(wstb[4]),
    .cv_wdata_i(wd), .rh_rd_i(rh_rd_i), .rl_rd_i(rl_rd_i),
    .hw_trigger_in_i(hw_trigger_in_i), .stop_mode_i(wstb[5]), .wait_mode_i(wait_mode_i),
    .alt_tick_i(tick_q), .async_tick_i(tick_q), .sar_data_i(sar_data_i),
    .status_control_one_o(sc1), .status_control_two_o(sc2), .converter_config_o(cfg),
    .compare_value_high_o(cvh), .compare_value_low_o(cvl), .result_high_o(rh), .result_low_o(rl),
    .complete_flag_o(flag), .irq_o(irq), .channel_select_o(chan), .sample_o(smp),
    .convert_o(cnv), .low_power_config_o(lp), .async_clk_en_o(aen), .wake_o(wake)
  );

  // One-cycle write strobe; selector 5 pulses stop mode instead
  task automatic wr(input int sel, input logic [7:0] d);
    @(posedge clk_sys_i);
    wstb <= 6'h01 << sel;
    wd <= d;
    @(posedge clk_sys_i);
    wstb <= 6'h00;
  endtask

  task automatic rd(input logic hi);
    @(posedge clk_sys_i);
    rh_rd_i <= hi;
    rl_rd_i <= ~hi;
    @(posedge clk_sys_i);
    rh_rd_i <= 1'b0;
    rl_rd_i <= 1'b0;
  endtask

  task automatic gap(input int k);
    repeat (k) @(posedge clk_sys_i);
    #1;
  endtask

  // Counts edges until the flag shows; the bound keeps a stuck design from hanging
  task automatic wait_flag(output int c);
    c = 0;
    #1;
    while (flag !== 1'b1 && c < 400) begin
      @(posedge clk_sys_i);
      #1;
      c++;
    end
  endtask

  task automatic finish_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 3000 cycles
  initial begin
    #(20 * 8000);
    n_mismatch++;
    finish_test();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    #1;
    `CHK(sc1, `SC1_RESET)
    `CHK({rh, rl, flag, aen}, 18'h00000)
    `CHK(chan, `CHAN_OFF)
    $display("reset test done");
    sar_data_i <= 10'h0a5;
    wr(0, 8'h41);
    wait_flag(n);
    `CHK(n >= 25 && n <= 28, 1'h1)
    `CHK({rh, rl}, 16'h00a5)
    `CHK({irq, wake}, 2'h2)
    @(posedge clk_sys_i);
    wait_mode_i <= 1'b1;
    #1;
    `CHK(wake, 1'h1)
    wr(0, 8'h1f);
    gap(40);
    `CHK({flag, sc2[7], irq, chan}, 8'h1f)
    $display("single test done");
    // Every mode-changing write, and stop mode, aborts mid-conversion
    for (int s = 1; s < 6; s++) begin
      wr(0, 8'h01);
      gap(20);
      `CHK({sc2[7], smp, cnv}, 3'h5)
      wr(s, 8'h00);
      gap(40);
      `CHK({flag, sc2[7], rl}, 10'h0a5)
    end
    $display("abort test done");
    // Low power bit rides along; it only reaches the analog core
    wr(2, 8'h98);
    sar_data_i <= 10'h2c3;
    wr(0, 8'h01);
    `CHK({cfg, lp}, 9'h131)
    wait_flag(n);
    `CHK(n >= 48 && n <= 51, 1'h1)
    `CHK({rh, rl}, 16'h02c3)
    // High byte read leaves the pair half read, so the next result is dropped
    rd(1'b1);
    sar_data_i <= 10'h1b4;
    wr(0, 8'h01);
    gap(60);
    `CHK({flag, sc2[7], rh, rl}, 18'h102c3)
    rd(1'b0);
    wait_flag(n);
    `CHK({rh, rl}, 16'h01b4)
    $display("blocking test done");
    // Compare against 0x100: equal passes upward, below fails then passes downward
    wr(2, 8'h08);
    wr(1, 8'h30);
    wr(3, 8'h01);
    wr(4, 8'h00);
    `CHK({cfg, cvh, cvl}, 24'h080100)
    sar_data_i <= 10'h100;
    wr(0, 8'h01);
    wait_flag(n);
    `CHK({rh, rl}, 16'h0000)
    sar_data_i <= 10'h0ff;
    wr(0, 8'h01);
    gap(40);
    `CHK({flag, sc2[7], rl}, 10'h000)
    wr(1, 8'h20);
    wr(0, 8'h01);
    wait_flag(n);
    `CHK({rh, rl}, 16'h03ff)
    $display("compare test done");
    wr(1, 8'h40);
    wr(2, 8'h00);
    sar_data_i <= 10'h055;
    wr(0, 8'h01);
    gap(3);
    `CHK(sc2[7], 1'h0)
    @(posedge clk_sys_i);
    hw_trigger_in_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    hw_trigger_in_i <= 1'b0;
    @(posedge clk_sys_i);
    hw_trigger_in_i <= 1'b1;
    wait_flag(n);
    `CHK(rl, 8'h55)
    gap(40);
    `CHK(sc2[7], 1'h0)
    hw_trigger_in_i <= 1'b0;
    $display("trigger test done");
    wr(1, 8'h00);
    sar_data_i <= 10'h033;
    wr(0, 8'h21);
    wait_flag(n);
    `CHK(n >= 25 && n <= 28, 1'h1)
    rd(1'b0);
    wait_flag(n);
    `CHK(n >= 14 && n <= 18, 1'h1)
    gap(5);
    wr(0, 8'h01);
    wait_flag(n);
    `CHK(n >= 25 && n <= 28, 1'h1)
    gap(40);
    `CHK(sc2[7], 1'h0)
    $display("continuous test done");
    wr(2, 8'h03);
    wr(0, 8'h01);
    gap(2);
    `CHK(aen, 1'h1)
    wait_flag(n);
    `CHK(n >= 290 && n <= 302, 1'h1)
    gap(1);
    `CHK(aen, 1'h0)
    $display("async test done");
    finish_test();
  end
endmodule // tb_adc_conversion_sequencer
